/* rtl/nsx_pkg.sv */
// shared constants for the nibble-exchange / xor / direction-load executor
package nsx_pkg;

    // opcode widths
    localparam int unsigned INSTR_W  = 14;
    localparam int unsigned DATA_W   = 8;
    localparam int unsigned FADDR_W  = 7;

    // byte-oriented opcode field, bits 13..8
    localparam logic [5:0] OPC_NIBBLE_EXCHANGE = 6'h0E;
    localparam logic [5:0] OPC_XOR_REGISTER    = 6'h06;
    localparam logic [5:0] OPC_XOR_LITERAL     = 6'h3A;

    // direction-load opcode, bits 13..3, operand in bits 2..0
    localparam logic [10:0] OPC_DIRECTION_LOAD = 11'h00C;

    // field positions
    localparam int unsigned OPC_HI     = 13;
    localparam int unsigned OPC_LO     = 8;
    localparam int unsigned DEST_BIT   = 7;
    localparam int unsigned FADDR_HI   = 6;
    localparam int unsigned DIRL_LO    = 3;
    localparam int unsigned DIRSEL_HI  = 2;

    // legal direction-load operands
    localparam logic [2:0] DIRSEL_FIRST = 3'h5;
    localparam logic [2:0] DIRSEL_LAST  = 3'h7;

    // file addresses where the three direction registers also appear
    localparam logic [6:0] DIR_FADDR_5 = 7'h45;
    localparam logic [6:0] DIR_FADDR_6 = 7'h46;
    localparam logic [6:0] DIR_FADDR_7 = 7'h47;

    // reset values
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET = 8'hFF;
    localparam logic       ZF_RESET  = 1'b0;

    // destination select encodings
    localparam logic DEST_ACC  = 1'b0;
    localparam logic DEST_FILE = 1'b1;

endpackage

/* rtl/nsx_exec.sv */
// decode and single-cycle execution of nibble exchange, direction load and the two xor forms
`timescale 1ns/100ps

// Functional notes
// - nibble exchange swaps halves, flags untouched
// - nibble exchange dest bit: 0 acc, 1 file
// - direction load copies acc, operands 5..7 only
// - direction registers also reachable by file addressing
// - literal xor into acc, updates zero flag
// - register xor with file, updates zero flag
// - register xor dest bit: 0 acc, 1 file
module nsx_exec
    import nsx_pkg::*;
(
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // instruction from fetch, one cycle per instruction
    input  wire logic               instr_valid,
    input  wire logic [13:0]        instr,
    // file read data for address instr[6:0], same cycle
    input  wire logic [7:0]         file_rd_data,
    // file write port, registered
    output logic                    file_wr_en,
    output logic [6:0]              file_wr_addr,
    output logic [7:0]              file_wr_data,
    // core state
    output logic [7:0]              acc,
    output logic                    zero_flag,
    // port direction registers for ports 5, 6, 7
    output logic [7:0]              dir_5,
    output logic [7:0]              dir_6,
    output logic [7:0]              dir_7,
    // one-cycle completion pulse
    output logic                    instr_done
);

    // decoded operation kinds
    typedef enum logic [2:0] {
        NSX_OP_NONE,
        NSX_OP_NIBBLE,
        NSX_OP_XOR_REG,
        NSX_OP_XOR_LIT,
        NSX_OP_DIR_LOAD
    } nsx_op_t;

    // true when a file address hits one of the direction registers
    function automatic logic is_dir_addr(input logic [6:0] a);
        return (a == DIR_FADDR_5) || (a == DIR_FADDR_6) || (a == DIR_FADDR_7);
    endfunction

    // exchange upper and lower halves of a byte
    function automatic logic [7:0] swap_nib(input logic [7:0] v);
        return {v[3:0], v[7:4]};
    endfunction

    nsx_op_t        op;             // decoded operation
    logic           dest;           // destination select bit
    logic [6:0]     faddr;          // file address field
    logic [2:0]     dirsel;         // direction-load operand
    logic [7:0]     literal;        // literal field
    logic [7:0]     src;            // selected file operand
    logic [7:0]     result;         // alu result

    logic           next_file_wr_en;
    logic [6:0]     next_file_wr_addr;
    logic [7:0]     next_file_wr_data;
    logic [7:0]     next_acc;
    logic           next_zero_flag;
    logic [7:0]     next_dir_5;
    logic [7:0]     next_dir_6;
    logic [7:0]     next_dir_7;
    logic           next_instr_done;

    // field extraction, fixed positions of the byte-oriented format
    assign dest    = instr[DEST_BIT];
    assign faddr   = instr[FADDR_HI:0];
    assign dirsel  = instr[DIRSEL_HI:0];
    assign literal = instr[DATA_W-1:0];

    // opcode decode; anything else is not ours and passes untouched
    always_comb
    begin
        op = NSX_OP_NONE;
        if (instr_valid)
        begin
            if (instr[OPC_HI:OPC_LO] == OPC_NIBBLE_EXCHANGE)
                op = NSX_OP_NIBBLE;
            else if (instr[OPC_HI:OPC_LO] == OPC_XOR_REGISTER)
                op = NSX_OP_XOR_REG;
            else if (instr[OPC_HI:OPC_LO] == OPC_XOR_LITERAL)
                op = NSX_OP_XOR_LIT;
            // operands below 5 have no register behind them, so are dropped
            else if (instr[OPC_HI:DIRL_LO] == OPC_DIRECTION_LOAD &&
                     dirsel >= DIRSEL_FIRST && dirsel <= DIRSEL_LAST)
                op = NSX_OP_DIR_LOAD;
        end
    end

    // file operand: direction registers read back through the file map
    always_comb
    begin
        src = file_rd_data;
        if (is_dir_addr(faddr))
        begin
            unique case (faddr)
                DIR_FADDR_5: src = dir_5;
                DIR_FADDR_6: src = dir_6;
                default:     src = dir_7;
            endcase
        end
    end

    // next state of every output register
    always_comb
    begin
        result            = 8'h00;
        next_file_wr_en   = 1'b0;
        next_file_wr_addr = file_wr_addr;
        next_file_wr_data = file_wr_data;
        next_acc          = acc;
        next_zero_flag    = zero_flag;
        next_dir_5        = dir_5;
        next_dir_6        = dir_6;
        next_dir_7        = dir_7;
        next_instr_done   = (op != NSX_OP_NONE);
        unique case (op)
            NSX_OP_NIBBLE:
                result = swap_nib(src);
            NSX_OP_XOR_REG:
            begin
                result         = acc ^ src;
                next_zero_flag = (result == 8'h00);
            end
            NSX_OP_XOR_LIT:
            begin
                result         = acc ^ literal;
                next_zero_flag = (result == 8'h00);
                next_acc       = result;
            end
            NSX_OP_DIR_LOAD:
            begin
                // status flags deliberately left alone
                unique case (dirsel)
                    DIRSEL_FIRST: next_dir_5 = acc;
                    3'h6:         next_dir_6 = acc;
                    default:      next_dir_7 = acc;
                endcase
            end
            default:
                result = 8'h00;
        endcase
        // destination routing for the two byte-oriented file forms
        if (op == NSX_OP_NIBBLE || op == NSX_OP_XOR_REG)
        begin
            if (dest == DEST_ACC)
                next_acc = result;
            else if (is_dir_addr(faddr))
            begin
                // write lands in the local register, not on the bus
                unique case (faddr)
                    DIR_FADDR_5: next_dir_5 = result;
                    DIR_FADDR_6: next_dir_6 = result;
                    default:     next_dir_7 = result;
                endcase
            end
            else
            begin
                next_file_wr_en   = 1'b1;
                next_file_wr_addr = faddr;
                next_file_wr_data = result;
            end
        end
    end

    // register stage; all outputs come straight from here
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            file_wr_en   <= 1'b0;
            file_wr_addr <= 7'h00;
            file_wr_data <= 8'h00;
            acc          <= ACC_RESET;
            zero_flag    <= ZF_RESET;
            dir_5        <= DIR_RESET;
            dir_6        <= DIR_RESET;
            dir_7        <= DIR_RESET;
            instr_done   <= 1'b0;
        end
        else
        begin
            file_wr_en   <= next_file_wr_en;
            file_wr_addr <= next_file_wr_addr;
            file_wr_data <= next_file_wr_data;
            acc          <= next_acc;
            zero_flag    <= next_zero_flag;
            dir_5        <= next_dir_5;
            dir_6        <= next_dir_6;
            dir_7        <= next_dir_7;
            instr_done   <= next_instr_done;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // decode strobes seen at the issue edge
    logic is_nib_w;
    logic is_nib_f;
    logic is_xr_w;
    logic is_xr_f;
    assign is_nib_w = (op == NSX_OP_NIBBLE)  && dest == DEST_ACC;
    assign is_nib_f = (op == NSX_OP_NIBBLE)  && dest == DEST_FILE && !is_dir_addr(faddr);
    assign is_xr_w  = (op == NSX_OP_XOR_REG) && dest == DEST_ACC;
    assign is_xr_f  = (op == NSX_OP_XOR_REG) && dest == DEST_FILE && !is_dir_addr(faddr);

    // any recognised word this cycle, kept as a plain signal so $past can look back at it
    logic op_hit;
    assign op_hit = (op != NSX_OP_NONE);

    sequence s_issue_nib_w;
        is_nib_w;
    endsequence
    sequence s_issue_xr_f;
        is_xr_f;
    endsequence

    chk_nibble_to_acc: assert property (
        s_issue_nib_w |=> acc == swap_nib($past(src)) && $stable(zero_flag) && !file_wr_en)
        else $error("nibble exchange to acc wrong");

    chk_nibble_to_file: assert property (
        is_nib_f |=> file_wr_en && file_wr_data == swap_nib($past(src)) && file_wr_addr == $past(faddr)
            && $stable(acc))
        else $error("nibble exchange to file wrong");

    chk_dirload_copy: assert property (
        (op == NSX_OP_DIR_LOAD && dirsel == 3'h6) |=> dir_6 == $past(acc) && $stable(zero_flag)
            && $stable(dir_5) && $stable(dir_7))
        else $error("direction load wrong");

    chk_dirload_range: assert property (
        (instr_valid && instr[OPC_HI:DIRL_LO] == OPC_DIRECTION_LOAD && dirsel < DIRSEL_FIRST)
            |=> !instr_done && $stable(dir_5) && $stable(dir_6) && $stable(dir_7))
        else $error("illegal direction operand acted on");

    chk_dir_filemap: assert property (
        (op == NSX_OP_XOR_REG && dest == DEST_FILE && faddr == DIR_FADDR_7)
            |=> dir_7 == ($past(acc) ^ $past(dir_7)) && !file_wr_en)
        else $error("direction register file access wrong");

    chk_xorlit_zero: assert property (
        (op == NSX_OP_XOR_LIT) |=> acc == ($past(acc) ^ $past(literal))
            && zero_flag == (acc == 8'h00))
        else $error("literal xor wrong");

    chk_xorreg_acc: assert property (
        is_xr_w |=> acc == ($past(acc) ^ $past(src)) && zero_flag == (acc == 8'h00))
        else $error("register xor to acc wrong");

    chk_xorreg_file: assert property (
        s_issue_xr_f |=> file_wr_en && file_wr_data == ($past(acc) ^ $past(src)) && $stable(acc)
            && zero_flag == (file_wr_data == 8'h00))
        else $error("register xor to file wrong");

    chk_single_cycle: assert property (
        op_hit |=> instr_done ##1 (instr_done == $past(op_hit)))
        else $error("instruction not completed in one cycle");

endmodule

/* verif/nsx_file_model.sv */
// file register space model that feeds the executor's read and write ports
`timescale 1ns/100ps
module nsx_file_model
    import nsx_pkg::*;
(
    // clock
    input  wire logic        clk,
    // read side, follows the instruction's address field
    input  wire logic        instr_valid,
    input  wire logic [13:0] instr,
    output logic [7:0]       file_rd_data,
    // write side from the executor
    input  wire logic        file_wr_en,
    input  wire logic [6:0]  file_wr_addr,
    input  wire logic [7:0]  file_wr_data
);
    logic [7:0] mem [128]; // file bytes, preloaded by the bench

    // same-cycle read; outside an instruction the bus shows inverted data
    // so a stale value can never pass for a fresh one
    always_comb
    begin
        if (instr_valid)
            file_rd_data = mem[instr[FADDR_HI:0]];
        else
            file_rd_data = ~mem[instr[FADDR_HI:0]];
    end

    // registered write, one byte per pulse; plain always since the bench preloads bytes too
    always @(posedge clk)
    begin
        if (file_wr_en)
            mem[file_wr_addr] <= file_wr_data;
    end
endmodule

/* verif/tb_top.sv */
// self-checking bench for the nibble-exchange / xor / direction-load executor
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
    $display("[FAIL] %0t got %h expected %h", $time, a, b); end end
module tb_top
    import nsx_pkg::*;
;
    logic        clk = 1'b0;    // 200 MHz core clock
    logic        rst_n = 1'b0;  // synchronous reset
    logic        instr_valid = 1'b0;
    logic [13:0] instr = 14'h0000;
    logic [7:0]  file_rd_data;
    logic        file_wr_en;
    logic [6:0]  file_wr_addr;
    logic [7:0]  file_wr_data;
    logic [7:0]  acc;
    logic        zero_flag;
    logic [7:0]  dir_5;
    logic [7:0]  dir_6;
    logic [7:0]  dir_7;
    logic        instr_done;
    logic [7:0]  ea;            // expected accumulator
    int          err_total = 0;
    int          check_count = 0;
    int          cycles = 0;

    always #2.5 clk = ~clk;

    nsx_exec nsx_exec_i (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
        .file_rd_data(file_rd_data), .file_wr_en(file_wr_en), .file_wr_addr(file_wr_addr),
        .file_wr_data(file_wr_data), .acc(acc), .zero_flag(zero_flag), .dir_5(dir_5),
        .dir_6(dir_6), .dir_7(dir_7), .instr_done(instr_done));

    nsx_file_model nsx_file_model_i (.clk(clk), .instr_valid(instr_valid), .instr(instr),
        .file_rd_data(file_rd_data), .file_wr_en(file_wr_en), .file_wr_addr(file_wr_addr),
        .file_wr_data(file_wr_data));

    // one instruction, then look one edge later when results have landed
    task automatic go(input logic [13:0] w, input logic done);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr       <= w;
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
        `CHK(instr_done, done)
    endtask

    task automatic t_xor_lit;
        go(14'h3AB5, 1'b1);
        `CHK(acc, 8'hB5)
        `CHK(zero_flag, 1'b0)
        go(14'h3AB5, 1'b1);
        `CHK(acc, 8'h00)
        `CHK(zero_flag, 1'b1)
    endtask

    task automatic t_swap;
        nsx_file_model_i.mem[32] = 8'hA5;
        go(14'h0E20, 1'b1);
        `CHK(acc, 8'h5A)
        `CHK(zero_flag, 1'b1)
        `CHK(file_wr_en, 1'b0)
        go(14'h0EA0, 1'b1);
        `CHK({file_wr_en, file_wr_addr, file_wr_data}, {1'b1, 7'h20, 8'h5A})
        `CHK(acc, 8'h5A)
        #5;
        `CHK({file_wr_en, instr_done}, 2'b00)
    endtask

    task automatic t_xor_reg;
        nsx_file_model_i.mem[33] = 8'hAF;
        nsx_file_model_i.mem[34] = 8'h5A;
        go(14'h06A1, 1'b1);
        `CHK({file_wr_en, file_wr_addr, file_wr_data}, {1'b1, 7'h21, 8'hF5})
        `CHK({acc, zero_flag}, {8'h5A, 1'b0})
        go(14'h0622, 1'b1);
        `CHK({acc, zero_flag, file_wr_en}, {8'h00, 1'b1, 1'b0})
    endtask

    // each operand 5..7 takes a different accumulator value
    task automatic t_dir;
        logic [7:0] ed [5:7];
        ed = '{8'hFF, 8'hFF, 8'hFF};
        ea = 8'h00;
        for (int s = 5; s <= 7; s++)
        begin
            ea = ea ^ (8'h10 | 8'(s));
            go(14'h3A10 | 14'(s), 1'b1);
            go(14'h0060 | 14'(s), 1'b1);
            ed[s] = ea;
            `CHK({dir_5, dir_6, dir_7}, {ed[5], ed[6], ed[7]})
            `CHK({acc, zero_flag}, {ea, 1'b0})
        end
        go(14'h0064, 1'b0);
        `CHK({dir_5, dir_6, dir_7, acc}, {ed[5], ed[6], ed[7], ea})
        go(14'h06C6, 1'b1);
        `CHK({dir_6, file_wr_en}, {ed[6] ^ ea, 1'b0})
        go(14'h06C7, 1'b1);
        `CHK({dir_7, file_wr_en}, {ed[7] ^ ea, 1'b0})
        `CHK(zero_flag, (ed[7] ^ ea) == 8'h00)
        go(14'h0E45, 1'b1);
        `CHK(acc, {ed[5][3:0], ed[5][7:4]})
        ea = {ed[5][3:0], ed[5][7:4]};
    endtask

    // two literals with no gap; each sees the previous result
    task automatic t_b2b;
        @(posedge clk);
        instr_valid <= 1'b1;
        instr       <= 14'h3A0F;
        @(posedge clk);
        instr       <= 14'h3AF0;
        #1;
        `CHK({acc, instr_done}, {ea ^ 8'h0F, 1'b1})
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
        `CHK({acc, instr_done}, {ea ^ 8'hFF, 1'b1})
    endtask

    task automatic stop_test;
        $display("errors %0d checks %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // hang guard, far above the roughly 40 cycles the run needs
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            err_total++;
            stop_test;
        end
    end

    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        `CHK({acc, zero_flag, dir_5, dir_6, dir_7}, {8'h00, 1'b0, 24'hFF_FFFF})
        `CHK({instr_done, file_wr_en}, 2'b00)
        t_xor_lit;
        t_swap;
        t_xor_reg;
        t_dir;
        t_b2b;
        stop_test;
    end
endmodule
